/* File: exec_pkg.sv */
// Shared constants and types for the extended instruction executor
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int PROG_W = 16;
  localparam int PAGE_W = 8;

  // **********************************************************
  // Operation codes
  // **********************************************************
  typedef enum logic [3:0] {
    OP_NIBBLE_EXCHANGE_IN_PLACE      = 4'h0,
    OP_NIBBLE_EXCHANGE_TO_ACC        = 4'h1,
    OP_SKIP_WHEN_BYTE_ZERO           = 4'h2,
    OP_COPY_THEN_SKIP_WHEN_ZERO      = 4'h3,
    OP_SKIP_WHEN_BIT_ZERO            = 4'h4,
    OP_TABLE_READ_CHOSEN_PAGE        = 4'h5,
    OP_TABLE_READ_FINAL_PAGE         = 4'h6,
    OP_PREINC_TABLE_READ_CHOSEN_PAGE = 4'h7,
    OP_PREINC_TABLE_READ_FINAL_PAGE  = 4'h8,
    OP_EXCLUSIVE_OR_INTO_ACC         = 4'h9,
    OP_EXCLUSIVE_OR_INTO_MEMORY      = 4'hA
  } exec_op_t;

  // **********************************************************
  // Reset values, final page number and cycle counts
  // **********************************************************
  localparam logic [7:0] ACC_RESET        = 8'h00;
  localparam logic [7:0] TBL_PTR_RESET    = 8'h00;
  localparam logic [7:0] TBL_HIGH_RESET   = 8'h00;
  localparam logic [7:0] FINAL_PAGE       = 8'hFF;
  localparam int         SKIP_CYCLES      = 3;
  localparam logic [1:0] DUMMY_CYCLES     = 2'(SKIP_CYCLES - 2);

endpackage

/* File: prog_port_if.sv */
// Program memory read port shared by executor and table reader
interface prog_port_if;
  import exec_pkg::*;
  logic              req;
  logic [15:0]       addr;
  logic              valid;
  logic [PROG_W-1:0] word;
  modport core (output req, output addr, input valid, input word);
  modport rdr  (input req, input addr, output valid, output word);
endinterface

/* File: table_reader.sv */
// Registered program memory table read stage
module table_reader (
  input  wire logic                  clk,
  input  wire logic                  reset,
  prog_port_if.rdr                   port,
  output      logic [15:0]           mem_addr,
  input  wire logic [exec_pkg::PROG_W-1:0] mem_rdata
);
  import exec_pkg::*;

  logic issued_q;

  // Address is presented one cycle, data captured the next
  always_ff @(posedge clk) begin
    if (reset) begin
      issued_q <= 1'b0;
      mem_addr <= 16'h0000;
    end else begin
      issued_q <= port.req & ~issued_q;
      if (port.req)
        mem_addr <= port.addr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      port.valid <= 1'b0;
      port.word  <= '0;
    end else begin
      port.valid <= issued_q;
      if (issued_q)
        port.word <= mem_rdata;
    end
  end

endmodule

/* File: swap_skip_table_xor_ops.sv */
// Executor for the swap, skip, table read and exclusive-or extended instructions
// Behaviour
// RQ1: In-place swap exchanges byte nibbles, writes back, flags untouched.
// RQ2: Swap-to-accumulator loads swapped nibbles into accumulator; memory, flags untouched.
// RQ3: Byte skip test rewrites same byte; skips next instruction when zero.
// RQ4: A taken skip inserts one dummy cycle, three cycles in all.
// RQ5: Copy-then-skip moves byte into accumulator, skips when zero.
// RQ6: Bit skip test skips when selected bit is zero, flags untouched.
// RQ7: Chosen-page read uses pointer high and low; low to memory, high latched.
// RQ8: Final-page read uses last page and pointer low byte only.
// RQ9: Preinc chosen-page read increments pointer low byte before reading.
// RQ10: Preinc final-page read increments pointer low byte before reading last page.
// RQ11: Exclusive-or into accumulator updates accumulator and only zero flag.
// RQ12: Exclusive-or into memory writes byte back and updates only zero flag.
module swap_skip_table_xor_ops (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic                    start,
  input  wire exec_pkg::exec_op_t      op,
  input  wire logic [2:0]              bit_sel,
  input  wire logic [7:0]              mem_rdata,
  output      logic                    mem_we,
  output      logic [7:0]              mem_wdata,
  output      logic [15:0]             prog_addr,
  input  wire logic [exec_pkg::PROG_W-1:0] prog_rdata,
  input  wire logic                    tbl_ptr_low_we,
  input  wire logic                    tbl_ptr_high_we,
  input  wire logic [7:0]              tbl_ptr_wdata,
  input  wire logic                    acc_we,
  input  wire logic [7:0]              acc_wdata,
  output      logic                    busy,
  output      logic                    done,
  output      logic                    skip,
  output      logic                    dummy_cycle,
  output      logic [7:0]              accumulator,
  output      logic [7:0]              table_high_latch,
  output      logic [7:0]              table_pointer_low_byte,
  output      logic [7:0]              table_pointer_high_byte,
  output      logic                    zero_flag
);
  import exec_pkg::*;

  // **********************************************************
  // State machine
  // **********************************************************
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_TABLE = 4'b0010,
    ST_DUMMY = 4'b0100,
    ST_FIN   = 4'b1000
  } state_t;

  state_t     state_q;
  exec_op_t   op_q;
  logic [7:0] operand_q;
  logic [1:0] dummy_cnt_q;
  logic       tbl_req_q;
  logic       is_table;
  logic       is_preinc;
  logic       is_final;
  logic       skip_d;
  logic [7:0] swapped;
  logic [7:0] xor_val;
  logic [7:0] ptr_low_used;

  prog_port_if port ();

  table_reader u_reader (
    .clk       (clk),
    .reset     (reset),
    .port      (port.rdr),
    .mem_addr  (prog_addr),
    .mem_rdata (prog_rdata)
  );

  assign swapped   = {mem_rdata[3:0], mem_rdata[7:4]};
  assign xor_val   = accumulator ^ mem_rdata;
  assign is_table  = (op inside {OP_TABLE_READ_CHOSEN_PAGE, OP_TABLE_READ_FINAL_PAGE,
                                 OP_PREINC_TABLE_READ_CHOSEN_PAGE,
                                 OP_PREINC_TABLE_READ_FINAL_PAGE});
  assign is_preinc = (op inside {OP_PREINC_TABLE_READ_CHOSEN_PAGE,
                                 OP_PREINC_TABLE_READ_FINAL_PAGE});
  // Page choice comes from the latched op: the live op may move on
  // while the reader is still being addressed
  assign is_final  = (op_q inside {OP_TABLE_READ_FINAL_PAGE,
                                   OP_PREINC_TABLE_READ_FINAL_PAGE});
  assign ptr_low_used = is_preinc ? 8'(table_pointer_low_byte + 8'h01)
                                  : table_pointer_low_byte;

  // Skip decision
  always_comb begin
    unique case (op)
      OP_SKIP_WHEN_BYTE_ZERO:      skip_d = (mem_rdata == 8'h00);   // RQ3
      OP_COPY_THEN_SKIP_WHEN_ZERO: skip_d = (mem_rdata == 8'h00);   // RQ5
      OP_SKIP_WHEN_BIT_ZERO:       skip_d = ~mem_rdata[bit_sel];    // RQ6
      default:                     skip_d = 1'b0;
    endcase
  end

  // Table request drives the reader for exactly one cycle
  assign port.req  = tbl_req_q;
  // Pointer already took its increment at the start edge, so the request
  // uses it as it stands; adding again here would step twice
  assign port.addr = is_final ? {FINAL_PAGE, table_pointer_low_byte}  // RQ8 RQ10
                              : {table_pointer_high_byte, table_pointer_low_byte}; // RQ7 RQ9

  assign busy = (state_q != ST_IDLE);

  always_ff @(posedge clk) begin
    if (reset)
      tbl_req_q <= 1'b0;
    else
      tbl_req_q <= start & ~busy & is_table;
  end

  // **********************************************************
  // Sequencer
  // **********************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q     <= ST_IDLE;
      op_q        <= OP_NIBBLE_EXCHANGE_IN_PLACE;
      dummy_cnt_q <= 2'b00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q <= op;
            if (is_table)
              state_q <= ST_TABLE;
            else if (skip_d) begin
              state_q     <= ST_DUMMY;   // RQ4
              dummy_cnt_q <= DUMMY_CYCLES;
            end else
              state_q <= ST_FIN;
          end
        end
        ST_TABLE: begin
          if (port.valid)
            state_q <= ST_FIN;
        end
        ST_DUMMY: begin
          // Dummy fetch slot stands in for the skipped instruction
          dummy_cnt_q <= dummy_cnt_q - 2'b01;
          if (dummy_cnt_q == 2'b01)
            state_q <= ST_FIN;           // RQ4
        end
        ST_FIN:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign dummy_cycle = (state_q == ST_DUMMY);

  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      skip <= 1'b0;
    end else begin
      done <= (state_q == ST_FIN);
      if (start && !busy)
        skip <= skip_d;                  // RQ4
    end
  end

  // **********************************************************
  // Data memory write-back
  // **********************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_we    <= 1'b0;
      mem_wdata <= 8'h00;
      operand_q <= 8'h00;
    end else begin
      mem_we <= 1'b0;
      if (start && !busy) begin
        operand_q <= mem_rdata;
        unique case (op)
          OP_NIBBLE_EXCHANGE_IN_PLACE: begin
            mem_we    <= 1'b1;
            mem_wdata <= swapped;        // RQ1
          end
          OP_SKIP_WHEN_BYTE_ZERO: begin
            mem_we    <= 1'b1;
            mem_wdata <= mem_rdata;      // RQ3
          end
          OP_EXCLUSIVE_OR_INTO_MEMORY: begin
            mem_we    <= 1'b1;
            mem_wdata <= xor_val;        // RQ12
          end
          default: ;
        endcase
      end else if (state_q == ST_TABLE && port.valid) begin
        mem_we    <= 1'b1;
        mem_wdata <= port.word[7:0];     // RQ7 RQ8 RQ9 RQ10
      end
    end
  end

  // **********************************************************
  // Accumulator and zero flag
  // **********************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      accumulator <= ACC_RESET;
      zero_flag   <= 1'b0;
    end else if (start && !busy) begin
      unique case (op)
        OP_NIBBLE_EXCHANGE_TO_ACC:   accumulator <= swapped;   // RQ2
        OP_COPY_THEN_SKIP_WHEN_ZERO: accumulator <= mem_rdata; // RQ5
        OP_EXCLUSIVE_OR_INTO_ACC: begin
          accumulator <= xor_val;                              // RQ11
          zero_flag   <= (xor_val == 8'h00);                   // RQ11
        end
        OP_EXCLUSIVE_OR_INTO_MEMORY:
          zero_flag <= (xor_val == 8'h00);                     // RQ12
        default: ;
      endcase
    end else if (acc_we && !busy)
      accumulator <= acc_wdata;
  end

  // **********************************************************
  // Table pointer and high latch
  // **********************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      table_pointer_low_byte  <= TBL_PTR_RESET;
      table_pointer_high_byte <= TBL_PTR_RESET;
    end else begin
      if (start && !busy && is_preinc)
        table_pointer_low_byte <= ptr_low_used;                // RQ9 RQ10
      else if (tbl_ptr_low_we && !busy)
        table_pointer_low_byte <= tbl_ptr_wdata;
      if (tbl_ptr_high_we && !busy)
        table_pointer_high_byte <= tbl_ptr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      table_high_latch <= TBL_HIGH_RESET;
    else if (state_q == ST_TABLE && port.valid)
      table_high_latch <= port.word[15:8];                     // RQ7 RQ8
  end

endmodule

/* File: exec_chk_sva.sv */
// Assertion checker for the extended instruction executor
module exec_chk_sva (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               start,
  input wire exec_pkg::exec_op_t op,
  input wire logic [2:0]         bit_sel,
  input wire logic [7:0]         mem_rdata,
  input wire logic               mem_we,
  input wire logic [7:0]         mem_wdata,
  input wire logic [15:0]        prog_addr,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               dummy_cycle,
  input wire logic [7:0]         accumulator,
  input wire logic [7:0]         table_pointer_low_byte,
  input wire logic               zero_flag
);
  import exec_pkg::*;
  // ****
  // Properties
  // ****
  logic go;
  assign go = start && !busy;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_swap_mem;
    go && op == OP_NIBBLE_EXCHANGE_IN_PLACE |->
      ##1 mem_we && mem_wdata == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])};
  endproperty
  a_swap_mem: assert property (p_swap_mem) else $error("swap write");
  property p_swap_acc;
    go && op == OP_NIBBLE_EXCHANGE_TO_ACC |->
      ##1 !mem_we && accumulator == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])};
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap acc");
  property p_byte_zero;
    go && op == OP_SKIP_WHEN_BYTE_ZERO |-> ##1 mem_we && mem_wdata == $past(mem_rdata);
  endproperty
  a_byte_zero: assert property (p_byte_zero) else $error("rewrite");
  // Taken skip: dummy, then completion one cycle late
  property p_skip_time;
    go && op == OP_SKIP_WHEN_BYTE_ZERO && mem_rdata == 8'h00 |->
      ##1 dummy_cycle ##1 !done ##1 done;
  endproperty
  a_skip_time: assert property (p_skip_time) else $error("skip timing");
  property p_bit_skip;
    go && op == OP_SKIP_WHEN_BIT_ZERO |-> ##1 dummy_cycle == !$past(mem_rdata[bit_sel]);
  endproperty
  a_bit_skip: assert property (p_bit_skip) else $error("bit skip");
  property p_tbl_inc;
    go && op == OP_PREINC_TABLE_READ_CHOSEN_PAGE |->
      ##3 prog_addr[7:0] == $past(table_pointer_low_byte, 3) + 8'h01;
  endproperty
  a_tbl_inc: assert property (p_tbl_inc) else $error("preinc address");
  property p_xor_mem;
    go && op == OP_EXCLUSIVE_OR_INTO_MEMORY |-> ##1 mem_we &&
      mem_wdata == ($past(accumulator) ^ $past(mem_rdata))
      ##1 zero_flag == ($past(mem_wdata) == 8'h00);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor memory");
  property p_xor_acc;
    go && op == OP_EXCLUSIVE_OR_INTO_ACC |-> ##1 zero_flag == (accumulator == 8'h00) &&
      accumulator == ($past(accumulator) ^ $past(mem_rdata));
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor acc");
  c_skip: cover property (dummy_cycle);
  c_tbl: cover property (go && op == OP_PREINC_TABLE_READ_FINAL_PAGE);
  c_zero: cover property (done && zero_flag);
endmodule
bind swap_skip_table_xor_ops exec_chk_sva chk (.clk, .reset, .start, .op, .bit_sel,
  .mem_rdata, .mem_we, .mem_wdata, .prog_addr, .busy, .done, .dummy_cycle, .accumulator,
  .table_pointer_low_byte, .zero_flag);

/* File: swap_skip_table_xor_ops_tb.sv */
// Self-checking bench for the extended instruction executor
module swap_skip_table_xor_ops_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import exec_pkg::*;
  // ****
  // Bench
  // ****
  typedef struct packed {
    exec_op_t   op;
    logic [2:0] b;
    logic [7:0] a, m, wd, ea;
    logic       we, sk, z;
  } row_t;
  logic        clk, reset, start, mem_we, busy, done, skip, dummy_cycle, zero_flag;
  logic        acc_we, tbl_ptr_low_we, tbl_ptr_high_we;
  exec_op_t    op;
  logic [2:0]  bit_sel;
  logic [7:0]  mem_rdata, mem_wdata, tbl_ptr_wdata, acc_wdata, accumulator, table_high_latch;
  logic [7:0]  table_pointer_low_byte, table_pointer_high_byte, cyc, wcnt, dmy, wd;
  logic [15:0] prog_addr, prog_rdata, pa;
  int          err_total, cmp_count;
  row_t rows [10] = '{
    '{OP_NIBBLE_EXCHANGE_IN_PLACE, 3'h0, 8'h11, 8'h3C, 8'hC3, 8'h11, 1'h1, 1'h0, 1'h0},
    '{OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h11, 8'hA5, 8'h00, 8'h5A, 1'h0, 1'h0, 1'h0},
    '{OP_SKIP_WHEN_BYTE_ZERO, 3'h0, 8'h22, 8'h00, 8'h00, 8'h22, 1'h1, 1'h1, 1'h0},
    '{OP_SKIP_WHEN_BYTE_ZERO, 3'h0, 8'h22, 8'h07, 8'h07, 8'h22, 1'h1, 1'h0, 1'h0},
    '{OP_COPY_THEN_SKIP_WHEN_ZERO, 3'h0, 8'h22, 8'h00, 8'h00, 8'h00, 1'h0, 1'h1, 1'h0},
    '{OP_SKIP_WHEN_BIT_ZERO, 3'h3, 8'h22, 8'hF7, 8'h00, 8'h22, 1'h0, 1'h1, 1'h0},
    '{OP_SKIP_WHEN_BIT_ZERO, 3'h7, 8'h22, 8'h80, 8'h00, 8'h22, 1'h0, 1'h0, 1'h0},
    '{OP_EXCLUSIVE_OR_INTO_ACC, 3'h0, 8'h5A, 8'h5A, 8'h00, 8'h00, 1'h0, 1'h0, 1'h1},
    '{OP_NIBBLE_EXCHANGE_TO_ACC, 3'h0, 8'h00, 8'h0F, 8'h00, 8'hF0, 1'h0, 1'h0, 1'h1},
    '{OP_EXCLUSIVE_OR_INTO_MEMORY, 3'h0, 8'h0F, 8'hF0, 8'hFF, 8'h0F, 1'h1, 1'h0, 1'h0}};
  // Table memory: word pattern derived from address so every address returns a distinct word
  assign prog_rdata = {prog_addr[7:0], prog_addr[15:8] ^ 8'hA5};
  swap_skip_table_xor_ops uut (.clk, .reset, .start, .op, .bit_sel, .mem_rdata, .mem_we,
    .mem_wdata, .prog_addr, .prog_rdata, .tbl_ptr_low_we, .tbl_ptr_high_we, .tbl_ptr_wdata,
    .acc_we, .acc_wdata, .busy, .done, .skip, .dummy_cycle, .accumulator, .table_high_latch,
    .table_pointer_low_byte, .table_pointer_high_byte, .zero_flag);
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Writes only while idle; each call starts on a fresh edge
  task automatic wr(input logic [2:0] w, input logic [7:0] v);
    @(posedge clk);
    {acc_we, tbl_ptr_high_we, tbl_ptr_low_we} <= w;
    acc_wdata <= v;
    tbl_ptr_wdata <= v;
    @(posedge clk);
    {acc_we, tbl_ptr_high_we, tbl_ptr_low_we} <= 3'h0;
  endtask
  task automatic run(input exec_op_t o, input logic [2:0] b, input logic [7:0] m, input int h);
    @(posedge clk);
    start <= 1'h1;
    op <= o;
    bit_sel <= b;
    mem_rdata <= m;
    repeat (h) @(posedge clk);
    start <= 1'h0;
    cyc = 8'(h);
    wcnt = 8'h00;
    dmy = 8'h00;
    // Strobes launched at the start edge stand only until the next one
    #1;
    while (done !== 1'h1 && cyc < 8'h0C) begin
      if (mem_we === 1'h1) begin
        wcnt++;
        wd = mem_wdata;
        pa = prog_addr;
      end
      if (dummy_cycle === 1'h1) dmy++;
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask
  task automatic tbl(input exec_op_t o, input logic [15:0] e, input int h);
    run(o, 3'h0, 8'h00, h);
    cmp16(pa, e);
    cmp16({wd, table_high_latch}, {e[15:8] ^ 8'hA5, e[7:0]});
    cmp16({table_pointer_low_byte, cyc}, {e[7:0], 8'h05});
  endtask
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #50us;
    err_total++;
    close_out();
  end
  initial begin
    {reset, start, acc_we, tbl_ptr_low_we, tbl_ptr_high_we} = 5'h10;
    op = OP_NIBBLE_EXCHANGE_IN_PLACE;
    bit_sel = 3'h0;
    {mem_rdata, tbl_ptr_wdata, acc_wdata} = 24'h0;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    #1;
    cmp16({accumulator, table_pointer_low_byte}, 16'h0000);
    cmp16({table_pointer_high_byte, table_high_latch}, 16'h0000);
    cmp8({3'h0, busy, done, skip, mem_we, zero_flag}, 8'h00);
    foreach (rows[i]) begin
      wr(3'h4, rows[i].a);
      run(rows[i].op, rows[i].b, rows[i].m, 1);
      cmp8(wcnt, {7'h0, rows[i].we});
      if (rows[i].we) cmp8(wd, rows[i].wd);
      cmp8(accumulator, rows[i].ea);
      cmp8({7'h0, skip}, {7'h0, rows[i].sk});
      cmp8({7'h0, zero_flag}, {7'h0, rows[i].z});
      cmp16({cyc, dmy}, {rows[i].sk ? 8'h03 : 8'h02, 7'h0, rows[i].sk});
    end
    wr(3'h2, 8'h12);
    wr(3'h1, 8'hFF);
    cmp8(table_pointer_high_byte, 8'h12);
    // Start held into busy must not trigger a second increment
    tbl(OP_PREINC_TABLE_READ_FINAL_PAGE, 16'hFF00, 2);
    tbl(OP_TABLE_READ_FINAL_PAGE, 16'hFF00, 1);
    tbl(OP_PREINC_TABLE_READ_CHOSEN_PAGE, 16'h1201, 1);
    tbl(OP_TABLE_READ_CHOSEN_PAGE, 16'h1201, 1);
    close_out();
  end
endmodule
